// ### pkg/ppmc_pkg.sv
// Operation
// RULE1 - Each pin is analog when its input mode bit is 0, digital when 1.
// RULE2 - Analog pins have weak pullup, output driver and input receiver turned off.
// RULE3 - Each output is open-drain when its output mode bit is 0, push-pull when 1.
// RULE4 - A skip bit of 1 makes the crossbar pass the pin; 0 leaves it available.
// RULE5 - Input mode register: page 0xF, address 0xEC, read/write, bits 7..1 reset to 1. The code resets bit 0 to 1 as well (0xFF).
// RULE6 - Output mode register: page 0xF, address 0xD9, read/write, resets to all zeros.
// RULE7 - Skip register: page 0xF, address 0xB6, read/write, resets to all zeros.
// RULE8 - Crossbar assigns signals in order to the next pin not skipped.
package ppmc_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [3:0] PPMC_PAGE = 4'hf;
    localparam logic [7:0] PPMC_ADDR_IN_MODE = 8'hec;
    localparam logic [7:0] PPMC_ADDR_OUT_MODE = 8'hd9;
    localparam logic [7:0] PPMC_ADDR_SKIP = 8'hb6;
    localparam logic [7:0] PPMC_RST_IN_MODE = 8'hff;
    localparam logic [7:0] PPMC_RST_OUT_MODE = 8'h00;
    localparam logic [7:0] PPMC_RST_SKIP = 8'h00;
    localparam int PPMC_PINS = 8;

    // -----------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ppmc_sfr_req_t;

    typedef struct packed {
        logic o;
        logic oe;
        logic pullup_en;
        logic rx_en;
    } ppmc_pad_t;
endpackage

// ### hdl/ppmc_pad_ctl.sv
`timescale 1ns/100ps
module ppmc_pad_ctl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic digital_mode,
    input wire logic push_pull,
    input wire logic out_val,
    input wire logic pad_i,
    output ppmc_pkg::ppmc_pad_t pad,
    output logic pin_value
);
    import ppmc_pkg::*;

    // -----------------------------------------------------------------
    // Pad drive
    // -----------------------------------------------------------------
    // Registered so the pad never sees glitches from the mode muxes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad <= '0;
        end else if (!digital_mode) begin
            pad <= '0; // RULE1 RULE2
        end else begin
            pad.o <= push_pull ? out_val : 1'b0; // RULE3
            pad.oe <= push_pull | ~out_val; // RULE3
            // Pullup only helps when we are not sinking the line
            pad.pullup_en <= ~(~push_pull & ~out_val) & ~push_pull; // RULE2
            pad.rx_en <= 1'b1;
        end
    end

    // Receiver off in analog mode: reads as 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_value <= 1'b0;
        end else begin
            pin_value <= digital_mode & pad_i; // RULE2
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    AST_ANALOG_OFF: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        !digital_mode |=> !pad.oe && !pad.pullup_en && !pad.rx_en && !pin_value)
        else $error("analog pin still has digital circuits on");
    AST_PUSH_PULL: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        digital_mode && push_pull |=> pad.oe && (pad.o == $past(out_val)))
        else $error("push-pull pin not driving its value");
    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        digital_mode && !push_pull |=> !pad.o && (pad.oe == !$past(out_val)))
        else $error("open-drain pin drives high");
endmodule // ppmc_pad_ctl

// ### hdl/ppmc_port.sv
`timescale 1ns/100ps
module ppmc_port (
    input wire logic clk,
    input wire logic rst_n,
    input ppmc_pkg::ppmc_sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    input wire logic [7:0] port_latch,
    input wire logic [7:0] periph_en,
    input wire logic [7:0] periph_out,
    input wire logic [7:0] pad_i,
    output wire ppmc_pkg::ppmc_pad_t [7:0] pad,
    output wire logic [7:0] pin_value,
    output logic [7:0] analog_mode,
    output logic [7:0] xbar_avail,
    output logic [7:0] xbar_owned
);
    import ppmc_pkg::*;

    logic [7:0] in_mode_q;
    logic [7:0] out_mode_q;
    logic [7:0] skip_q;
    logic [7:0] owned_d;
    logic [7:0] drive_d;
    logic [2:0] src_idx [8];
    logic hit_in;
    logic hit_out;
    logic hit_skip;

    // -----------------------------------------------------------------
    // Register decode
    // -----------------------------------------------------------------
    function automatic logic sfr_hit(input ppmc_sfr_req_t r, input logic [7:0] a);
        return (r.page == PPMC_PAGE) && (r.addr == a);
    endfunction

    assign hit_in = sfr_hit(sfr, PPMC_ADDR_IN_MODE); // RULE5
    assign hit_out = sfr_hit(sfr, PPMC_ADDR_OUT_MODE); // RULE6
    assign hit_skip = sfr_hit(sfr, PPMC_ADDR_SKIP); // RULE7

    // Input mode register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_mode_q <= PPMC_RST_IN_MODE; // RULE5
        end else if (sfr.wr && hit_in) begin
            in_mode_q <= sfr.wdata; // RULE5
        end
    end

    // Output mode register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_mode_q <= PPMC_RST_OUT_MODE; // RULE6
        end else if (sfr.wr && hit_out) begin
            out_mode_q <= sfr.wdata; // RULE6
        end
    end

    // Skip register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_q <= PPMC_RST_SKIP; // RULE7
        end else if (sfr.wr && hit_skip) begin
            skip_q <= sfr.wdata; // RULE7
        end
    end

    // Read data is held until the next read; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr.rd) begin
            if (hit_in) begin
                sfr_rdata <= in_mode_q;
            end else if (hit_out) begin
                sfr_rdata <= out_mode_q;
            end else if (hit_skip) begin
                sfr_rdata <= skip_q;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    // -----------------------------------------------------------------
    // Crossbar priority assignment
    // -----------------------------------------------------------------
    // Enabled peripheral signals take free pins in order; skipped pins
    // are passed over. Analog pins are not excluded here: software must
    // also skip them, as a pin in analog mode ignores any drive.
    always_comb begin
        int next_k;
        logic found;
        found = 1'b0;
        next_k = 0;
        owned_d = 8'h00;
        drive_d = 8'h00;
        for (int i = 0; i < PPMC_PINS; i++) begin
            src_idx[i] = 3'h0;
            found = 1'b0;
            if (!skip_q[i]) begin // RULE4 RULE8
                for (int j = 0; j < PPMC_PINS; j++) begin
                    if (!found && j >= next_k && periph_en[j]) begin
                        found = 1'b1;
                        src_idx[i] = j[2:0];
                        next_k = j + 1;
                    end
                end
            end
            owned_d[i] = found; // RULE8
            drive_d[i] = found ? periph_out[src_idx[i]] : port_latch[i];
        end
    end

    // Status outputs from flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_mode <= ~PPMC_RST_IN_MODE;
            xbar_avail <= ~PPMC_RST_SKIP;
            xbar_owned <= 8'h00;
        end else begin
            analog_mode <= ~in_mode_q; // RULE1
            xbar_avail <= ~skip_q; // RULE4
            xbar_owned <= owned_d; // RULE8
        end
    end

    // -----------------------------------------------------------------
    // Pad control per pin
    // -----------------------------------------------------------------
    for (genvar g = 0; g < PPMC_PINS; g++) begin : g_pin
        ppmc_pad_ctl u_pad (
            .clk(clk),
            .rst_n(rst_n),
            .digital_mode(in_mode_q[g]),
            .push_pull(out_mode_q[g]),
            .out_val(drive_d[g]),
            .pad_i(pad_i[g]),
            .pad(pad[g]),
            .pin_value(pin_value[g])
        );
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    AST_IN_MODE_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        sfr.wr && sfr.page == 4'hf && sfr.addr == 8'hec |=> in_mode_q == $past(sfr.wdata))
        else $error("input mode write lost");
    AST_OUT_MODE_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        sfr.wr && sfr.page == 4'hf && sfr.addr == 8'hd9 |=> out_mode_q == $past(sfr.wdata))
        else $error("output mode write lost");
    AST_SKIP_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        sfr.wr && sfr.page == 4'hf && sfr.addr == 8'hb6 |=> ##1 xbar_avail == ~$past(sfr.wdata, 2))
        else $error("skip write not reflected");
    AST_READ_BACK: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        sfr.rd && !sfr.wr && hit_in |=> sfr_rdata == $past(in_mode_q))
        else $error("input mode read mismatch");
    AST_ANALOG_STATUS: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        1'b1 |=> analog_mode == ~$past(in_mode_q))
        else $error("analog status wrong");
    AST_SKIP_NOT_OWNED: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        1'b1 |=> (xbar_owned & ~xbar_avail) == 8'h00)
        else $error("skipped pin taken by crossbar");
    AST_FIRST_FREE: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        periph_en[0] && !skip_q[0] |-> owned_d[0] && src_idx[0] == 3'h0)
        else $error("first peripheral not on first free pin");
    AST_COUNT_MATCH: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        (~skip_q == 8'hff) |-> owned_d == ((8'h01 << $countones(periph_en)) - 8'h01))
        else $error("crossbar did not pack pins in order");

    // -----------------------------------------------------------------
    // Register hold and read-back checks
    // -----------------------------------------------------------------
    // A register may only move on a write that decodes to it
    AST_IN_MODE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        !(sfr.wr && hit_in) |=> in_mode_q == $past(in_mode_q))
        else $error("input mode changed without a write");
    // Writes to another page must leave the output mode alone
    AST_OUT_MODE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        !(sfr.wr && hit_out) |=> out_mode_q == $past(out_mode_q))
        else $error("output mode changed without a write");
    // Skip bits steer the crossbar, so a stray change would move pins
    AST_SKIP_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        !(sfr.wr && hit_skip) |=> skip_q == $past(skip_q))
        else $error("skip register changed without a write");
    // Read data returns the output mode register
    AST_OUT_READ_BACK: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        sfr.rd && !sfr.wr && hit_out |=> sfr_rdata == $past(out_mode_q))
        else $error("output mode read mismatch");
    // Read data returns the skip register
    AST_SKIP_READ_BACK: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        sfr.rd && !sfr.wr && hit_skip |=> sfr_rdata == $past(skip_q))
        else $error("skip read mismatch");
    // Unmapped reads return zero so software never sees stale bits
    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_n) // RULE5 RULE6 RULE7
        sfr.rd && !hit_in && !hit_out && !hit_skip |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    // Read data stands until the next read strobe
    AST_READ_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE5 RULE6 RULE7
        !sfr.rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");

    // -----------------------------------------------------------------
    // Crossbar and pad checks
    // -----------------------------------------------------------------
    // Skip status follows the register one cycle later
    AST_AVAIL_STATUS: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        1'b1 |=> xbar_avail == ~$past(skip_q))
        else $error("crossbar availability wrong");
    // A skipped pin is never handed out
    AST_SKIPPED_FREE: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        1'b1 |-> (owned_d & skip_q) == 8'h00)
        else $error("skipped pin assigned a peripheral");
    // A skipped pin keeps driving its latch value
    AST_SKIPPED_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        1'b1 |-> ((drive_d ^ port_latch) & skip_q) == 8'h00)
        else $error("skipped pin not driven from latch");
    // Every free pin is used until the enabled signals run out
    AST_OWN_COUNT: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        1'b1 |-> $countones(owned_d) == (($countones(periph_en) < $countones(~skip_q)) ?
            $countones(periph_en) : $countones(~skip_q)))
        else $error("crossbar left a free pin unused");
    // Analog pins must read as zero through the receiver
    AST_ANALOG_READS_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        1'b1 |-> (pin_value & analog_mode) == 8'h00)
        else $error("analog pin reads a digital value");
endmodule // ppmc_port

// ### bench/ppmc_pins.sv
`timescale 1ns/100ps
// Pin wires: device drive wins, then outside drive, then pullup
module ppmc_pins (
    input wire logic clk,
    input ppmc_pkg::ppmc_pad_t [7:0] pad,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_i
);
    import ppmc_pkg::*;
    logic float_q = 1'b0;
    // Undriven pins wobble so a missing pullup cannot hide
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_i[i] = pad[i].oe ? pad[i].o : ext_en[i] ? ext_val[i] : pad[i].pullup_en | float_q;
        end
    end
endmodule // ppmc_pins

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
    import ppmc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ppmc_sfr_req_t sfr = '0;
    logic [7:0] port_latch = 8'h00, periph_en = 8'h00, periph_out = 8'h00;
    logic [7:0] ext_en = 8'h00, ext_val = 8'h00, pad_i, sfr_rdata, pin_value;
    logic [7:0] analog_mode, xbar_avail, xbar_owned;
    ppmc_pad_t [7:0] pad;
    int err_total = 0, total_checks = 0;
    always #5 clk = ~clk;
    ppmc_port dut (.clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .port_latch(port_latch), .periph_en(periph_en), .periph_out(periph_out),
        .pad_i(pad_i), .pad(pad), .pin_value(pin_value), .analog_mode(analog_mode),
        .xbar_avail(xbar_avail), .xbar_owned(xbar_owned));
    ppmc_pins pins (.clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Drive value is only meaningful while the pin is driven
    task automatic chk_pad(input int i, input ppmc_pad_t e, input ppmc_pad_t g);
        if (!e.oe) g.o = e.o;
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch pad%0d expected %b seen %b", i, e, g);
        end
    endtask
    // An idle edge after each strobe keeps one assignment per time step
    task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
        sfr <= '{page: pg, addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        sfr.wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rdchk(input string nm, input logic [3:0] pg, input logic [7:0] a,
        input logic [7:0] e);
        sfr <= '{page: pg, addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        sfr.rd <= 1'b0;
        chk8(nm, e, sfr_rdata);
        @(negedge clk);
    endtask
    function automatic logic [7:0] r8();
        return 8'($urandom);
    endfunction
    function automatic ppmc_pad_t exp_pad(input logic dig, input logic pp, input logic v);
        ppmc_pad_t p;
        p = '0;
        if (dig) begin
            p = '{o: v, oe: pp | ~v, pullup_en: ~pp & v, rx_en: 1'b1};
        end
        return p;
    endfunction
    // Enabled signals fill the free pins in ascending order
    function automatic logic [15:0] exp_xbar(input logic [7:0] skp, en, po);
        int k;
        logic [7:0] own, val;
        k = 0;
        own = '0;
        val = '0;
        for (int p = 0; p < 8; p++) begin
            while (k < 8 && !en[k]) k++;
            if (!skp[p] && k < 8) begin
                own[p] = 1'b1;
                val[p] = po[k];
                k++;
            end
        end
        return {own, val};
    endfunction
    initial begin
        #50us;
        err_total++;
        print_verdict();
    end
    initial begin
        logic [7:0] im, om, sk, en, po, lt, ee, m;
        logic [15:0] xb;
        ppmc_pad_t e;
        void'($urandom(37647));
        repeat (10) @(negedge clk);
        rst_n <= 1'b1;
        rdchk("in_mode", 4'hf, 8'hec, 8'hff);
        rdchk("out_mode", 4'hf, 8'hd9, 8'h00);
        rdchk("skip", 4'hf, 8'hb6, 8'h00);
        rdchk("unmapped", 4'hf, 8'h8b, 8'h00);
        wr(4'h0, 8'hd9, 8'hff);
        rdchk("out_mode_page", 4'hf, 8'hd9, 8'h00);
        for (int n = 0; n < 24; n++) begin
            im = r8(); om = r8(); sk = r8(); en = r8(); po = r8(); lt = r8(); ee = r8();
            if (n == 0) begin
                im = 8'hff; om = 8'hff; sk = 8'h01; en = 8'h03;
            end
            if (n == 1) im = 8'h00;
            if (n == 2) sk = 8'hff;
            port_latch <= lt; periph_en <= en; periph_out <= po; ext_en <= ee; ext_val <= r8();
            wr(4'hf, 8'hec, im);
            wr(4'hf, 8'hd9, om);
            wr(4'hf, 8'hb6, sk);
            rdchk("in_mode", 4'hf, 8'hec, im);
            rdchk("out_mode", 4'hf, 8'hd9, om);
            rdchk("skip", 4'hf, 8'hb6, sk);
            chk8("analog_mode", ~im, analog_mode);
            chk8("xbar_avail", ~sk, xbar_avail);
            xb = exp_xbar(sk, en, po);
            chk8("xbar_owned", xb[15:8], xbar_owned);
            for (int i = 0; i < 8; i++) begin
                e = exp_pad(im[i], om[i], xb[8+i] ? xb[i] : lt[i]);
                m[i] = ~im[i] | e.oe | e.pullup_en | ee[i];
                chk_pad(i, e, pad[i]);
            end
            chk8("pin_value", im & pad_i & m, pin_value & m);
        end
        // Reset in mid-run must restore digital mode
        rst_n <= 1'b0;
        @(negedge clk);
        rst_n <= 1'b1;
        rdchk("in_mode_rst", 4'hf, 8'hec, 8'hff);
        print_verdict();
    end
endmodule // tb
